// *** include/erfir_defines.svh ***
`ifndef ERFIR_DEFINES_SVH
`define ERFIR_DEFINES_SVH

// ************************************************************
// Filter settings, lengths and reciprocal gains
// ************************************************************
`define ERFIR_NUM_SETTINGS 3'h6
`define ERFIR_LEN_0        7'h02
`define ERFIR_LEN_1        7'h05
`define ERFIR_LEN_2        7'h0a
`define ERFIR_LEN_3        7'h18
`define ERFIR_LEN_4        7'h33
`define ERFIR_LEN_5        7'h75
// Reciprocals of the lengths, scaled by 2**16 and rounded
`define ERFIR_RCP_0        16'h8000
`define ERFIR_RCP_1        16'h3333
`define ERFIR_RCP_2        16'h199a
`define ERFIR_RCP_3        16'h0aab
`define ERFIR_RCP_4        16'h0505
`define ERFIR_RCP_5        16'h0230

// ************************************************************
// Output format
// ************************************************************
`define ERFIR_IN_W         8
`define ERFIR_FRAC_W       3
`define ERFIR_OUT_W        11
`define ERFIR_PROD_LSB     13
`define ERFIR_FIFO_DEPTH   8

`endif

// *** include/erfir_pkg.sv ***
`default_nettype none
package erfir_pkg;

    typedef enum logic [2:0]
    {
        ERFIR_IDLE   = 3'b000,
        ERFIR_CHECK  = 3'b001,
        ERFIR_READ   = 3'b010,
        ERFIR_DRAIN  = 3'b011,
        ERFIR_SCALE  = 3'b100,
        ERFIR_PUSH   = 3'b101
    } erfir_state_t;

    typedef logic [7:0] erfir_sample_t;

endpackage

`default_nettype wire

// *** hdl/erfir_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none

module erfir_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input  wire logic             clk,       // Processing clock
    input  wire logic             rst_n,     // Synchronous reset, active low
    input  wire logic             ce,        // Clock enable
    input  wire logic             in_valid,  // Write request
    output logic                  in_ready,  // Space available
    input  wire logic [WIDTH-1:0] in_data,   // Write data
    output logic                  out_valid, // Data available
    input  wire logic             out_ready, // Reader takes word
    output logic      [WIDTH-1:0] out_data   // Head word
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic             do_wr;
    logic             do_rd;

    assign in_ready  = (count < (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign do_wr     = ce && in_valid && in_ready;
    assign do_rd     = ce && out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (do_wr)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Head word is registered so the output never glitches on a write
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            out_data <= '0;
        end
        else if (ce)
        begin
            if (do_rd && count > (PW+1)'(1))
            begin
                out_data <= mem[PW'(rd_ptr + 1'b1)];
            end
            else if (do_wr && (count == '0 || (do_rd && count == (PW+1)'(1))))
            begin
                out_data <= in_data;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr <= PW'(wr_ptr + 1'b1);
            end
            if (do_rd)
            begin
                rd_ptr <= PW'(rd_ptr + 1'b1);
            end
            count <= (PW+1)'(count + (do_wr ? 1 : 0) - (do_rd ? 1 : 0));
        end
    end

endmodule // erfir_fifo

`default_nettype wire

// *** hdl/erfir_top.sv ***
// Notes on behaviour
// - Six settings, 0.5 to 3 bits in half-bit steps, chosen by ENH_SEL 0..5.
// - Each setting roughly halves bandwidth of the one before.
// - Filter lengths 2, 5, 10, 24, 51, 117 samples.
// - Cutoffs 0.5, 0.241, 0.121, 0.058, 0.029, 0.016 of Nyquist.
// - Group delay removed; each output tagged with its aligned input index.
// - Taps sum to unity at DC; in-range input never overflows output.
// - Overflowed inputs still filtered; touched outputs flagged unreliable.
// - Output record is input length minus filter length, trimmed both ends.
// - Record too short for any output is refused, nothing produced.
// - Input is raw 8-bit ADC code; no accuracy or linearity correction.
// - Works on one stored record; no repeated acquisitions needed.
`timescale 1ns/100ps
`default_nettype none
`include "erfir_defines.svh"

module erfir_top
#(
    parameter int AW = 16   // Record address width
)
(
    input  wire logic                     CLK,       // 200 MHz processing clock
    input  wire logic                     RST_N,     // Synchronous reset
    input  wire logic                     CE,        // Freezes all state when low
    input  wire logic                     START,     // Filter request pulse
    input  wire logic [2:0]               ENH_SEL,   // Enhancement setting 0..5
    input  wire logic [AW-1:0]            REC_LEN,   // Input record length
    output logic                          BUSY,      // Filtering in progress
    output logic                          DONE,      // Record finished pulse
    output logic                          REFUSED,   // Request refused pulse
    output logic                          MEM_RD,    // Sample read strobe
    output logic [AW-1:0]                 MEM_ADDR,  // Sample address
    input  wire erfir_pkg::erfir_sample_t MEM_DATA,  // Sample, cycle after strobe
    input  wire logic                     MEM_OVF,   // Sample was overflowed
    output logic                          OUT_VALID, // Output word available
    input  wire logic                     OUT_READY, // Trace store takes word
    output logic [`ERFIR_OUT_W-1:0]       OUT_DATA,  // Filtered sample
    output logic [AW-1:0]                 OUT_INDEX, // Aligned input index
    output logic                          OUT_UNREL  // Window held an overflow
);
    import erfir_pkg::*;

    localparam int FW = `ERFIR_OUT_W + AW + 1;

    // ************************************************************
    // Request capture and per-setting constants
    // ************************************************************
    erfir_state_t  state;
    logic [6:0]    flen;
    logic [15:0]   rcp;
    logic [AW-1:0] rec_len;
    logic [AW-1:0] out_total;
    logic [AW-1:0] out_pos;
    logic [6:0]    tap;
    logic          rd_pend;
    logic [14:0]   acc;
    logic          ovf_seen;
    logic [30:0]   prod;
    logic          fifo_ready;
    logic [FW-1:0] fifo_in;
    logic [FW-1:0] fifo_out;
    logic [6:0]    next_flen;
    logic [15:0]   next_rcp;
    logic          sel_ok;

    always_comb
    begin
        sel_ok = 1'b1;
        unique case (ENH_SEL)
            3'h0:
            begin
                next_flen = `ERFIR_LEN_0;
                next_rcp  = `ERFIR_RCP_0;
            end
            3'h1:
            begin
                next_flen = `ERFIR_LEN_1;
                next_rcp  = `ERFIR_RCP_1;
            end
            3'h2:
            begin
                next_flen = `ERFIR_LEN_2;
                next_rcp  = `ERFIR_RCP_2;
            end
            3'h3:
            begin
                next_flen = `ERFIR_LEN_3;
                next_rcp  = `ERFIR_RCP_3;
            end
            3'h4:
            begin
                next_flen = `ERFIR_LEN_4;
                next_rcp  = `ERFIR_RCP_4;
            end
            3'h5:
            begin
                next_flen = `ERFIR_LEN_5;
                next_rcp  = `ERFIR_RCP_5;
            end
            default:
            begin
                next_flen = `ERFIR_LEN_5;
                next_rcp  = `ERFIR_RCP_5;
                sel_ok    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            flen    <= '0;
            rcp     <= '0;
            rec_len <= '0;
        end
        else if (CE && state == ERFIR_IDLE && START)
        begin
            flen    <= next_flen;
            rcp     <= next_rcp;
            rec_len <= sel_ok ? REC_LEN : '0;
        end
    end

    // Output count; length equal to filter length leaves nothing
    assign out_total = (rec_len > AW'(flen)) ? AW'(rec_len - AW'(flen)) : '0;

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            state   <= ERFIR_IDLE;
            out_pos <= '0;
            tap     <= '0;
            DONE    <= 1'b0;
            REFUSED <= 1'b0;
        end
        else if (CE)
        begin
            DONE    <= 1'b0;
            REFUSED <= 1'b0;
            unique case (state)
                ERFIR_IDLE:
                begin
                    if (START)
                    begin
                        state <= ERFIR_CHECK;
                    end
                end
                ERFIR_CHECK:
                begin
                    out_pos <= '0;
                    tap     <= '0;
                    if (out_total == '0)
                    begin
                        REFUSED <= 1'b1;
                        state   <= ERFIR_IDLE;
                    end
                    else
                    begin
                        state <= ERFIR_READ;
                    end
                end
                ERFIR_READ:
                begin
                    tap <= 7'(tap + 1'b1);
                    if (tap == 7'(flen - 1'b1))
                    begin
                        state <= ERFIR_DRAIN;
                    end
                end
                ERFIR_DRAIN:
                begin
                    state <= ERFIR_SCALE;
                end
                ERFIR_SCALE:
                begin
                    state <= ERFIR_PUSH;
                end
                ERFIR_PUSH:
                begin
                    // Stalls here while the output buffer is full
                    if (fifo_ready)
                    begin
                        tap     <= '0;
                        out_pos <= AW'(out_pos + 1'b1);
                        if (out_pos == AW'(out_total - 1'b1))
                        begin
                            DONE  <= 1'b1;
                            state <= ERFIR_IDLE;
                        end
                        else
                        begin
                            state <= ERFIR_READ;
                        end
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Memory reads and accumulation
    // ************************************************************
    // One stored record, read once per window; no re-acquisition
    assign MEM_RD   = CE && state == ERFIR_READ;
    assign MEM_ADDR = AW'(out_pos + AW'(tap));
    assign BUSY     = (state != ERFIR_IDLE);

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            rd_pend <= 1'b0;
        end
        else if (CE)
        begin
            rd_pend <= MEM_RD;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            acc      <= '0;
            ovf_seen <= 1'b0;
        end
        else if (CE)
        begin
            if ((state == ERFIR_PUSH && fifo_ready) || state == ERFIR_CHECK)
            begin
                acc      <= '0;
                ovf_seen <= 1'b0;
            end
            else if (rd_pend)
            begin
                acc      <= 15'(acc + 15'(MEM_DATA));
                ovf_seen <= ovf_seen | MEM_OVF;
            end
        end
    end

    // Equal taps scaled by the rounded reciprocal; a rectangular window
    // trades stopband depth for a multiplier-free tap path
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            prod <= '0;
        end
        else if (CE && state == ERFIR_SCALE)
        begin
            prod <= acc * rcp;
        end
    end

    // ************************************************************
    // Output buffer
    // ************************************************************
    // Index of the window's centre: half the trim leads, odd one trails
    assign fifo_in = {ovf_seen,
                      AW'(out_pos + AW'(flen >> 1)),
                      prod[`ERFIR_PROD_LSB +: `ERFIR_OUT_W]};

    erfir_fifo
    #(
        .WIDTH (FW),
        .DEPTH (`ERFIR_FIFO_DEPTH)
    )
    u_fifo
    (
        .clk       (CLK),
        .rst_n     (RST_N),
        .ce        (CE),
        .in_valid  (state == ERFIR_PUSH),
        .in_ready  (fifo_ready),
        .in_data   (fifo_in),
        .out_valid (OUT_VALID),
        .out_ready (OUT_READY),
        .out_data  (fifo_out)
    );

    assign OUT_UNREL = fifo_out[FW-1];
    assign OUT_INDEX = fifo_out[`ERFIR_OUT_W +: AW];
    assign OUT_DATA  = fifo_out[`ERFIR_OUT_W-1:0];

endmodule // erfir_top

`default_nettype wire

// *** dv/erfir_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "erfir_defines.svh"
module erfir_properties
#(
    parameter int AW = 16
)
(
    input wire logic                    CLK,       // clock
    input wire logic                    RST_N,     // reset
    input wire logic                    CE,        // enable
    input wire logic                    START,     // request
    input wire logic [2:0]              ENH_SEL,   // setting
    input wire logic [AW-1:0]           REC_LEN,   // length
    input wire logic                    BUSY,      // busy
    input wire logic                    DONE,      // done
    input wire logic                    REFUSED,   // refused
    input wire logic                    MEM_RD,    // read
    input wire logic [AW-1:0]           MEM_ADDR,  // address
    input wire logic                    OUT_VALID, // valid
    input wire logic                    OUT_READY, // ready
    input wire logic [`ERFIR_OUT_W-1:0] OUT_DATA,  // data
    input wire logic [AW-1:0]           OUT_INDEX  // index
);
    localparam logic [6:0] LEN [8] = '{`ERFIR_LEN_0, `ERFIR_LEN_1, `ERFIR_LEN_2,
        `ERFIR_LEN_3, `ERFIR_LEN_4, `ERFIR_LEN_5, 7'h7f, 7'h7f};
    logic bad;
    // Codes 6 and 7 map to an impossible length, refused either way
    assign bad = ENH_SEL > 3'h5 || REC_LEN <= AW'(LEN[ENH_SEL]);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    sequence s_take;
        CE && !BUSY && START;
    endsequence
    property p_refuse;
        s_take ##0 bad ##1 CE |=> REFUSED;
    endproperty
    property p_accept;
        s_take ##0 !bad ##1 CE [*2] |-> MEM_RD && MEM_ADDR == '0 && !REFUSED;
    endproperty
    property p_pulse;
        (REFUSED || DONE) && CE |=> !REFUSED && !DONE;
    endproperty
    property p_idle;
        !BUSY |-> !MEM_RD;
    endproperty
    property p_rdseq;
        MEM_RD && CE ##1 MEM_RD |-> MEM_ADDR == $past(MEM_ADDR) + 1'b1;
    endproperty
    property p_hold;
        OUT_VALID && !(OUT_READY && CE) |=>
            OUT_VALID && $stable(OUT_DATA) && $stable(OUT_INDEX);
    endproperty
    property p_range;
        OUT_VALID |-> OUT_DATA <= 11'h7f8;
    endproperty
    property p_end;
        $fell(BUSY) |-> DONE || REFUSED;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refusal missing");
    a_accept: assert property (p_accept) else $error("read not started");
    a_pulse: assert property (p_pulse) else $error("pulse too long");
    a_idle: assert property (p_idle) else $error("read while idle");
    a_rdseq: assert property (p_rdseq) else $error("address skip");
    a_hold: assert property (p_hold) else $error("output not held");
    a_range: assert property (p_range) else $error("output overflow");
    a_end: assert property (p_end) else $error("busy ended silently");
endmodule // erfir_properties

bind erfir_top erfir_properties #(.AW(AW)) prop_u
(
    .CLK(CLK), .RST_N(RST_N), .CE(CE), .START(START), .ENH_SEL(ENH_SEL),
    .REC_LEN(REC_LEN), .BUSY(BUSY), .DONE(DONE), .REFUSED(REFUSED),
    .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .OUT_INDEX(OUT_INDEX)
);
`default_nettype wire

// *** dv/erfir_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module erfir_mem_model
#(
    parameter int AW = 16
)
(
    input  wire logic                     clk,  // clock
    input  wire logic                     ce,   // enable
    input  wire logic                     rd,   // read strobe
    input  wire logic [AW-1:0]            addr, // address
    output erfir_pkg::erfir_sample_t      data, // sample
    output logic                          ovf   // overflow mark
);
    import erfir_pkg::*;
    erfir_sample_t mem [256];
    logic          omk [256];
    // Unread cycles scramble the lines so a late sample cannot pass;
    // a frozen reader sees them held
    always_ff @(posedge clk)
    begin
        if (rd && ce)
        begin
            data <= mem[addr[7:0]];
            ovf  <= omk[addr[7:0]];
        end
        else if (ce)
        begin
            data <= ~data;
            ovf  <= ~ovf;
        end
    end
endmodule // erfir_mem_model
`default_nettype wire

// *** dv/erfir_top_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "erfir_defines.svh"
module erfir_top_test;
    import erfir_pkg::*;
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          ce = 1'b1;
    logic          start = 1'b0;
    logic [2:0]    sel = 3'h0;
    logic [15:0]   rec_len = 16'h0000;
    logic          out_ready = 1'b0;
    bit            ce_gap = 1'b0;
    logic          busy, done, refused, mem_rd, mem_ovf, out_valid, out_unrel;
    logic [15:0]   mem_addr, out_index;
    logic [10:0]   out_data;
    erfir_sample_t mem_data;
    logic [10:0]   q_d [$];
    logic [15:0]   q_i [$];
    logic          q_u [$];
    int n_mismatch, check_count, n_done, n_ref, n_rd, cyc;
    int flen [6] = '{`ERFIR_LEN_0, `ERFIR_LEN_1, `ERFIR_LEN_2,
        `ERFIR_LEN_3, `ERFIR_LEN_4, `ERFIR_LEN_5};
    int rcp [6] = '{`ERFIR_RCP_0, `ERFIR_RCP_1, `ERFIR_RCP_2,
        `ERFIR_RCP_3, `ERFIR_RCP_4, `ERFIR_RCP_5};

    erfir_top #(.AW(16)) dut_u
    (
        .CLK(clk), .RST_N(rst_n), .CE(ce), .START(start), .ENH_SEL(sel),
        .REC_LEN(rec_len), .BUSY(busy), .DONE(done), .REFUSED(refused),
        .MEM_RD(mem_rd), .MEM_ADDR(mem_addr), .MEM_DATA(mem_data),
        .MEM_OVF(mem_ovf), .OUT_VALID(out_valid), .OUT_READY(out_ready),
        .OUT_DATA(out_data), .OUT_INDEX(out_index), .OUT_UNREL(out_unrel)
    );
    erfir_mem_model #(.AW(16)) mem_u
    (
        .clk(clk), .ce(ce), .rd(mem_rd), .addr(mem_addr),
        .data(mem_data), .ovf(mem_ovf)
    );

    always #2.5 clk = ~clk;

    // ****************************************
    // Monitor and checking
    // ****************************************
    always @(posedge clk)
    begin
        cyc++;
        if (rst_n && out_valid === 1'b1 && out_ready && ce)
        begin
            q_d.push_back(out_data);
            q_i.push_back(out_index);
            q_u.push_back(out_unrel);
        end
        n_done += int'(done === 1'b1 && ce);
        n_ref += int'(refused === 1'b1 && ce);
        n_rd += int'(mem_rd === 1'b1);
        if (cyc == 20000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic chk(input bit bad, input string m);
        check_count++;
        if (bad)
        begin
            n_mismatch++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask

    task automatic request(input int s, input int len);
        q_d.delete();
        q_i.delete();
        q_u.delete();
        n_done = 0;
        n_ref = 0;
        n_rd = 0;
        sel <= 3'(s);
        rec_len <= 16'(len);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask

    task automatic t_refuse(input int s, input int len);
        request(s, len);
        out_ready <= 1'b1;
        repeat (6) @(posedge clk);
        chk(n_ref != 1, "no refusal");
        chk(n_rd != 0 || q_d.size() != 0, "output after refusal");
        chk(busy !== 1'b0, "busy after refusal");
    endtask

    task automatic t_run(input int s, input int len, input int stall);
        int l, e, u, k, j;
        l = flen[s];
        request(s, len);
        // Long stall fills the buffer and holds the filter back
        for (k = 0; k < 9000 && !(n_done > 0 && q_d.size() == len - l); k++)
        begin
            @(posedge clk);
            out_ready <= (k > stall);
            start <= (k == 3);
            ce <= !(ce_gap && k % 3 == 1);
        end
        repeat (8) @(posedge clk);
        ce <= 1'b1;
        chk(n_done != 1, "done count");
        chk(busy !== 1'b0, "busy after record");
        chk(q_d.size() != len - l, "output count");
        for (j = 0; j < len - l && j < q_d.size(); j++)
        begin
            e = 0;
            u = 0;
            for (k = j; k < j + l; k++)
            begin
                e += mem_u.mem[k];
                u |= mem_u.omk[k];
            end
            chk(q_d[j] !== 11'((e * rcp[s]) >> 13), "data");
            chk(q_i[j] !== 16'(j + l / 2), "index");
            chk(q_u[j] !== 1'(u), "unreliable flag");
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        for (int i = 0; i < 256; i++)
        begin
            mem_u.mem[i] = (i < 12) ? 8'hff : 8'(i * 53 + 7);
            mem_u.omk[i] = (i == 40);
        end
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_refuse(6, 200);
        t_refuse(7, 200);
        t_refuse(2, 10);
        t_refuse(5, 117);
        t_run(0, 3, 0);
        t_run(0, 30, 60);
        t_run(1, 40, 0);
        t_run(2, 45, 100);
        t_run(3, 50, 0);
        t_run(4, 70, 600);
        ce_gap = 1'b1;
        t_run(1, 40, 20);
        ce_gap = 1'b0;
        t_run(5, 130, 300);
        test_done();
    end
endmodule // erfir_top_test
`default_nettype wire
